// ### cmpc_pkg.sv
// constants, offsets and types shared by the mode and privilege controller
package cmpc_pkg;

    // =====================================================================
    // register map (byte addresses on the AHB-Lite slave)
    // =====================================================================
    localparam logic [7:0]  STATUS_WORD_ADDR = 8'h00;
    localparam logic [7:0]  MODE_STATE_ADDR  = 8'h04;
    localparam int          ADDR_DECODE_BITS = 8;

    // =====================================================================
    // processor status word, low half
    // =====================================================================
    localparam int FLAG_CARRY      = 0;
    localparam int FLAG_ZERO       = 1;
    localparam int FLAG_SIGN       = 2;
    localparam int FLAG_OVERFLOW   = 3;
    localparam int FLAG_SATURATION = 4;
    localparam int BIT_LOCK        = 5;
    localparam int BIT_SCRATCH     = 14;
    localparam int BIT_REMAP       = 15;
    localparam logic [15:0] LOW_WRITE_MASK = 16'hc03f;

    // =====================================================================
    // processor status word, high half
    // =====================================================================
    localparam int BIT_GLOBAL_MASK = 16;
    localparam int BIT_LEVEL0_MASK = 17;
    localparam int BIT_EXCEPT_MASK = 21;
    localparam int MODE_LSB        = 22;
    localparam int MODE_MSB        = 24;
    localparam int BIT_SECURE      = 25;
    localparam int BIT_DEBUG       = 26;
    localparam int LEVEL_COUNT     = 4;
    localparam logic [15:0] HIGH_WRITE_MASK = 16'h03ff;

    // =====================================================================
    // execution modes and priority ranks (1 highest, 7 means no rank)
    // =====================================================================
    typedef enum logic [2:0] {
        MODE_APPLICATION = 3'b000,
        MODE_SUPERVISOR  = 3'b001,
        MODE_LEVEL_ZERO  = 3'b010,
        MODE_LEVEL_ONE   = 3'b011,
        MODE_LEVEL_TWO   = 3'b100,
        MODE_LEVEL_THREE = 3'b101,
        MODE_EXCEPTION   = 3'b110,
        MODE_NMI         = 3'b111
    } cmpc_mode_type;

    localparam logic [2:0] RANK_NONE     = 3'h7;
    localparam int         REQUEST_COUNT = 6;

    // reset: supervisor mode, every interrupt level and exceptions masked
    localparam logic [31:0] STATUS_WORD_RESET = 32'h007f_0000;

    // =====================================================================
    // stack push sequence: slots 0..4 general registers, then pc, then word
    // =====================================================================
    typedef enum logic [0:0] {
        SEQ_IDLE = 1'b0,
        SEQ_PUSH = 1'b1
    } cmpc_seq_type;

    localparam logic [2:0] SLOT_FIRST_GPR = 3'h0;
    localparam logic [2:0] SLOT_RETURN_PC = 3'h5;
    localparam logic [2:0] SLOT_STATUS    = 3'h6;

    // rank of a mode; supervisor and application carry none
    function automatic logic [2:0] cmpc_rank(input logic [2:0] mode);
        case (mode)
            MODE_NMI:         cmpc_rank = 3'h1;
            MODE_EXCEPTION:   cmpc_rank = 3'h2;
            MODE_LEVEL_THREE: cmpc_rank = 3'h3;
            MODE_LEVEL_TWO:   cmpc_rank = 3'h4;
            MODE_LEVEL_ONE:   cmpc_rank = 3'h5;
            MODE_LEVEL_ZERO:  cmpc_rank = 3'h6;
            default:          cmpc_rank = RANK_NONE;
        endcase
    endfunction

    // mode that belongs to a rank
    function automatic logic [2:0] cmpc_mode_of_rank(input logic [2:0] rank);
        case (rank)
            3'h1:    cmpc_mode_of_rank = MODE_NMI;
            3'h2:    cmpc_mode_of_rank = MODE_EXCEPTION;
            3'h3:    cmpc_mode_of_rank = MODE_LEVEL_THREE;
            3'h4:    cmpc_mode_of_rank = MODE_LEVEL_TWO;
            3'h5:    cmpc_mode_of_rank = MODE_LEVEL_ONE;
            3'h6:    cmpc_mode_of_rank = MODE_LEVEL_ZERO;
            default: cmpc_mode_of_rank = MODE_SUPERVISOR;
        endcase
    endfunction

endpackage

// ### cmpc_event_arbiter.sv
// priority selector for pending mode-change requests
module cmpc_event_arbiter
    import cmpc_pkg::*;
#(
    parameter int REQUESTS = REQUEST_COUNT
) (
    input  wire logic [REQUESTS-1:0] request_in,
    input  wire logic [2:0]          current_rank_in,
    output logic                     grant_valid_out,
    output logic [2:0]               grant_rank_out
);

    // =====================================================================
    // pick lowest index (highest priority); bit i carries rank i+1
    // =====================================================================
    logic [2:0] best_rank;

    always_comb begin
        best_rank = RANK_NONE;
        for (int i = REQUESTS - 1; i >= 0; i--) begin
            if (request_in[i]) begin
                best_rank = 3'(i + 1);
            end
        end
    end

    // strictly higher priority only
    assign grant_valid_out = (best_rank < current_rank_in);
    assign grant_rank_out  = best_rank;

endmodule // cmpc_event_arbiter

// ### cmpc_mode_control.sv
// execution mode, privilege and debug/secure state control with AHB slave
//
// The AHB-Lite register port and the register addresses were decided locally.
module cmpc_mode_control
    import cmpc_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        rst_b_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // event requests (levels, held until served)
    input  wire logic [3:0]  interrupt_level_in,
    input  wire logic        nmi_request_in,
    input  wire logic        exception_request_in,
    input  wire logic        debug_enter_in,
    input  wire logic        debug_return_in,
    input  wire logic        event_return_in,
    input  wire logic [31:0] restored_status_in,
    // stack push data feed
    input  wire logic [31:0] push_item_in,
    input  wire logic [31:0] return_pc_in,
    output logic             push_valid_out,
    output logic [2:0]       push_slot_out,
    output logic [31:0]      push_data_out,
    // privilege checks from the pipeline
    input  wire logic        privileged_instr_in,
    input  wire logic        sysreg_access_in,
    input  wire logic        sysreg_open_in,
    input  wire logic        mem_access_in,
    input  wire logic        mem_protected_in,
    input  wire logic        secure_access_in,
    output logic             instr_refused_out,
    output logic             sysreg_denied_out,
    output logic             mem_denied_out,
    output logic             secure_denied_out,
    output logic [2:0]       mode_out,
    output logic             privileged_out,
    output logic             debug_state_out,
    output logic [31:0]      status_word_out
);

    // =====================================================================
    // reset release
    // =====================================================================
    logic rst_sync_a;
    logic rst_b;

    always_ff @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rst_sync_a <= 1'b0;
            rst_b      <= 1'b0;
        end else begin
            rst_sync_a <= 1'b1;
            rst_b      <= rst_sync_a;
        end
    end

    // =====================================================================
    // state
    // =====================================================================
    logic [31:0]  processor_status_word;
    logic [31:0]  debug_saved_word;
    cmpc_seq_type seq_state;
    logic [2:0]   push_slot;
    logic [2:0]   entry_mode;
    logic [31:0]  entry_saved_word;

    logic [2:0]   current_mode;
    logic         in_debug;
    logic         privileged;
    logic [3:0]   level_mask;
    logic [5:0]   request_vec;
    logic         grant_valid;
    logic [2:0]   grant_rank;
    logic         take_event;

    assign current_mode = processor_status_word[MODE_MSB:MODE_LSB];
    assign in_debug     = processor_status_word[BIT_DEBUG];
    assign level_mask   =
        processor_status_word[BIT_LEVEL0_MASK +: LEVEL_COUNT];
    // debug grants full privilege in any mode
    assign privileged   = (current_mode != MODE_APPLICATION)
                          || in_debug;

    // =====================================================================
    // request ranking
    // =====================================================================
    logic glob_off;
    assign glob_off = processor_status_word[BIT_GLOBAL_MASK];

    assign request_vec[0] = nmi_request_in;
    assign request_vec[1] = exception_request_in
                            && !processor_status_word[BIT_EXCEPT_MASK];

    genvar lv;
    generate
        for (lv = 0; lv < LEVEL_COUNT; lv++) begin : g_level
            // rank 3 is level three, rank 6 is level zero
            assign request_vec[5 - lv] = interrupt_level_in[lv]
                                         && !level_mask[lv]
                                         && !glob_off;
        end
    endgenerate

    cmpc_event_arbiter #(
        .REQUESTS (REQUEST_COUNT)
    ) u_arbiter (
        .request_in      (request_vec),
        .current_rank_in (cmpc_rank(current_mode)),
        .grant_valid_out (grant_valid),
        .grant_rank_out  (grant_rank)
    );

    // hardware events enter only between push sequences
    assign take_event = grant_valid && (seq_state == SEQ_IDLE)
                        && !debug_enter_in;

    // =====================================================================
    // ahb-lite address phase capture
    // =====================================================================
    logic       phase_valid;
    logic       phase_write;
    logic [7:0] phase_addr;
    logic       accept;

    assign accept = hsel_in && htrans_in[1] && hready_in;

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            phase_valid <= 1'b0;
            phase_write <= 1'b0;
            phase_addr  <= 8'h00;
        end else begin
            phase_valid <= accept;
            phase_write <= accept && hwrite_in;
            phase_addr  <= haddr_in[ADDR_DECODE_BITS-1:0];
        end
    end

    logic sw_status_write;
    assign sw_status_write = phase_valid && phase_write
                             && (phase_addr == STATUS_WORD_ADDR);

    // mode state register for software
    logic [31:0] mode_state_view;
    assign mode_state_view = {16'h0000,
                              1'b0, request_vec,
                              seq_state == SEQ_PUSH, in_debug,
                              privileged, cmpc_rank(current_mode),
                              current_mode};

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            hrdata_out <= 32'h0000_0000;
        end else if (accept && !hwrite_in) begin
            case (haddr_in[ADDR_DECODE_BITS-1:0])
                STATUS_WORD_ADDR: begin
                    // high half reads zero in unprivileged code
                    hrdata_out <= privileged ? processor_status_word
                                  : {16'h0000,
                                     processor_status_word[15:0]};
                end
                MODE_STATE_ADDR: hrdata_out <= mode_state_view;
                default:         hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;

    // =====================================================================
    // status word update; hardware events win over software writes
    // =====================================================================
    logic [31:0] next_status_word;
    logic [31:0] sw_merged;

    always_comb begin
        sw_merged = processor_status_word;
        sw_merged[15:0] = (processor_status_word[15:0] & ~LOW_WRITE_MASK)
                          | (hwdata_in[15:0] & LOW_WRITE_MASK);
        if (privileged) begin
            sw_merged[31:16] =
                (processor_status_word[31:16] & ~HIGH_WRITE_MASK)
                | (hwdata_in[31:16] & HIGH_WRITE_MASK);
        end
    end

    always_comb begin
        next_status_word = processor_status_word;
        if (sw_status_write) begin
            next_status_word = sw_merged;
        end
        if (event_return_in && !in_debug) begin
            next_status_word = restored_status_in;
            next_status_word[BIT_DEBUG] = 1'b0;
        end
        if (seq_state == SEQ_PUSH && push_slot == SLOT_STATUS) begin
            next_status_word[MODE_MSB:MODE_LSB] = entry_mode;
        end
        if (debug_return_in && in_debug) begin
            next_status_word = debug_saved_word;
            next_status_word[BIT_DEBUG] = 1'b0;
        end
        if (debug_enter_in && !in_debug) begin
            next_status_word[BIT_DEBUG] = 1'b1;
            next_status_word[BIT_LEVEL0_MASK +: LEVEL_COUNT] = 4'hf;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            processor_status_word <= STATUS_WORD_RESET;
        end else begin
            processor_status_word <= next_status_word;
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            debug_saved_word <= STATUS_WORD_RESET;
        end else if (debug_enter_in && !in_debug) begin
            debug_saved_word <= processor_status_word;
        end
    end

    // =====================================================================
    // event entry: push sequence onto the system stack
    // =====================================================================
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            seq_state        <= SEQ_IDLE;
            push_slot        <= SLOT_FIRST_GPR;
            entry_mode       <= MODE_SUPERVISOR;
            entry_saved_word <= 32'h0000_0000;
        end else begin
            case (seq_state)
                SEQ_IDLE: begin
                    if (take_event) begin
                        seq_state        <= SEQ_PUSH;
                        entry_mode       <= cmpc_mode_of_rank(grant_rank);
                        entry_saved_word <= processor_status_word;
                        // interrupts save the general registers too
                        push_slot <= (grant_rank > 3'h2) ? SLOT_FIRST_GPR
                                     : SLOT_RETURN_PC;
                    end
                end
                SEQ_PUSH: begin
                    if (push_slot == SLOT_STATUS) begin
                        seq_state <= SEQ_IDLE;
                    end else begin
                        push_slot <= push_slot + 3'h1;
                    end
                end
                default: seq_state <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            push_valid_out <= 1'b0;
            push_slot_out  <= SLOT_FIRST_GPR;
            push_data_out  <= 32'h0000_0000;
        end else begin
            push_valid_out <= (seq_state == SEQ_PUSH);
            push_slot_out  <= push_slot;
            case (push_slot)
                SLOT_STATUS:    push_data_out <= entry_saved_word;
                SLOT_RETURN_PC: push_data_out <= return_pc_in;
                default:        push_data_out <= push_item_in;
            endcase
        end
    end

    // =====================================================================
    // privilege checks
    // =====================================================================
    always_ff @(posedge clock_in or negedge rst_b) begin
        if (!rst_b) begin
            instr_refused_out <= 1'b0;
            sysreg_denied_out <= 1'b0;
            mem_denied_out    <= 1'b0;
            secure_denied_out <= 1'b0;
        end else begin
            instr_refused_out <= privileged_instr_in && !privileged;
            sysreg_denied_out <= sysreg_access_in && !sysreg_open_in
                                 && !privileged;
            mem_denied_out    <= mem_access_in && mem_protected_in
                                 && !privileged;
            secure_denied_out <= secure_access_in
                && !processor_status_word[BIT_SECURE];
        end
    end

    assign mode_out        = current_mode;
    assign privileged_out  = privileged;
    assign debug_state_out = in_debug;
    assign status_word_out = processor_status_word;

endmodule // cmpc_mode_control

// ### cmpc_mode_control_properties.sv
// port-level assertions for the mode and privilege controller
module cmpc_checker
    import cmpc_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        rst_b_in,
    input wire logic        privileged_instr_in,
    input wire logic        sysreg_access_in,
    input wire logic        sysreg_open_in,
    input wire logic        mem_access_in,
    input wire logic        mem_protected_in,
    input wire logic        secure_access_in,
    input wire logic        debug_return_in,
    input wire logic        instr_refused_out,
    input wire logic        sysreg_denied_out,
    input wire logic        mem_denied_out,
    input wire logic        secure_denied_out,
    input wire logic        privileged_out,
    input wire logic        debug_state_out,
    input wire logic        push_valid_out,
    input wire logic [2:0]  push_slot_out,
    input wire logic [2:0]  mode_out,
    input wire logic [31:0] status_word_out
);
    // =================================================================
    // properties
    // =================================================================
    logic user_mode;
    assign user_mode = (mode_out == MODE_APPLICATION) && !debug_state_out;
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (!rst_b_in);

    AST_PRIV_MODE: assert property (mode_out != 3'h0 |-> privileged_out)
        else $error("system mode not privileged");
    AST_APP_UNPRIV: assert property (user_mode |-> !privileged_out)
        else $error("application mode privileged");
    AST_INSTR: assert property (
        privileged_instr_in && user_mode |=> instr_refused_out)
        else $error("privileged instruction not refused");
    AST_INSTR_OK: assert property (!user_mode |=> !instr_refused_out)
        else $error("instruction refused in privileged state");
    AST_SYSREG: assert property (
        sysreg_access_in && !sysreg_open_in && user_mode
        |=> sysreg_denied_out)
        else $error("system register not blocked");
    AST_MEM: assert property (
        mem_access_in && mem_protected_in && user_mode |=> mem_denied_out)
        else $error("protected memory not denied");
    AST_SECURE: assert property (
        secure_access_in && !status_word_out[BIT_SECURE]
        |=> secure_denied_out)
        else $error("secure resource not denied");
    AST_DEBUG_MASK: assert property (
        $rose(debug_state_out)
        |-> status_word_out[BIT_LEVEL0_MASK +: LEVEL_COUNT] == 4'hf)
        else $error("levels not masked on debug entry");
    AST_DEBUG_HOLD: assert property (
        debug_state_out && !debug_return_in |=> debug_state_out)
        else $error("debug left without return");
    AST_PUSH_ORDER: assert property (
        push_valid_out && push_slot_out != 3'h6
        |=> push_valid_out
            && push_slot_out == $past(push_slot_out) + 3'h1)
        else $error("push slots out of order");
endmodule // cmpc_checker

bind cmpc_mode_control cmpc_checker u_cmpc_checker (
    .clock_in(clock_in), .rst_b_in(rst_b_in),
    .privileged_instr_in(privileged_instr_in),
    .sysreg_access_in(sysreg_access_in), .sysreg_open_in(sysreg_open_in),
    .mem_access_in(mem_access_in), .mem_protected_in(mem_protected_in),
    .secure_access_in(secure_access_in), .debug_return_in(debug_return_in),
    .instr_refused_out(instr_refused_out),
    .sysreg_denied_out(sysreg_denied_out), .mem_denied_out(mem_denied_out),
    .secure_denied_out(secure_denied_out), .privileged_out(privileged_out),
    .debug_state_out(debug_state_out), .push_valid_out(push_valid_out),
    .push_slot_out(push_slot_out), .mode_out(mode_out),
    .status_word_out(status_word_out));

// ### tb_top.sv
// self-checking testbench for the mode and privilege controller
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cmpc_pkg::*;
    typedef struct {
        logic [31:0] sw;
        logic [5:0]  req;
        logic [3:0]  deny;
    } cmpc_row_type;
    logic        clock_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        hsel_in = 1'b0;
    logic        hwrite_in = 1'b0;
    logic [1:0]  htrans_in = 2'h0;
    logic [31:0] haddr_in = 32'h0;
    logic [31:0] hwdata_in = 32'h0;
    logic [3:0]  irq = 4'h0;
    logic        nmi = 1'b0;
    logic        exc = 1'b0;
    logic        dbg_in = 1'b0;
    logic        dbg_ret = 1'b0;
    logic        ev_ret = 1'b0;
    logic [31:0] restore = 32'h0;
    logic [5:0]  req = 6'h0;
    logic [31:0] hrdata_out, push_data_out, status_word_out, rd;
    logic        hreadyout_out, hresp_out, push_valid_out;
    logic        privileged_out, debug_state_out;
    logic [2:0]  push_slot_out, mode_out;
    wire logic [3:0] deny;
    int          n_mismatch = 0;
    int          comparisons = 0;
    cmpc_row_type rows [7] = '{
        '{32'h0040_0000, 6'h37, 4'h1}, '{32'h0240_0000, 6'h21, 4'h0},
        '{32'h0002_0000, 6'h20, 4'h8}, '{32'h0000_0000, 6'h10, 4'h4},
        '{32'h0000_0000, 6'h18, 4'h0}, '{32'h0000_0000, 6'h06, 4'h2},
        '{32'h0000_0000, 6'h04, 4'h0}};

    cmpc_mode_control u_cmpc_mode_control (
        .clock_in(clock_in), .rst_b_in(rst_b_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(3'h2), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
        .hresp_out(hresp_out), .interrupt_level_in(irq),
        .nmi_request_in(nmi), .exception_request_in(exc),
        .debug_enter_in(dbg_in), .debug_return_in(dbg_ret),
        .event_return_in(ev_ret), .restored_status_in(restore),
        .push_item_in(32'h1234_5678), .return_pc_in(32'h0000_0100),
        .push_valid_out(push_valid_out), .push_slot_out(push_slot_out),
        .push_data_out(push_data_out), .privileged_instr_in(req[5]),
        .sysreg_access_in(req[4]), .sysreg_open_in(req[3]),
        .mem_access_in(req[2]), .mem_protected_in(req[1]),
        .secure_access_in(req[0]), .instr_refused_out(deny[3]),
        .sysreg_denied_out(deny[2]), .mem_denied_out(deny[1]),
        .secure_denied_out(deny[0]), .mode_out(mode_out),
        .privileged_out(privileged_out), .debug_state_out(debug_state_out),
        .status_word_out(status_word_out));

    always #10 clock_in = ~clock_in;

    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask

    task automatic chk4(input logic [3:0] got, exp, input string what);
        chk32({28'h0, got}, {28'h0, exp}, what);
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge clock_in);
    endtask

    // waits for ready (0), a pushed word (1) or mode m (2)
    task automatic wait_for(input int which, input logic [2:0] m);
        int n;
        n = 0;
        @(posedge clock_in);
        while (!(which == 0 ? hreadyout_out === 1'b1 :
                 which == 1 ? push_valid_out === 1'b1 : mode_out === m)) begin
            n++;
            if (n > 40) begin
                n_mismatch++;
                $display("[FAIL] %0t wait timed out", $time);
                report_and_stop();
            end
            @(posedge clock_in);
        end
    endtask

    task automatic ahb(input logic wr, input logic [31:0] a, d);
        hsel_in <= 1'b1;
        htrans_in <= 2'h2;
        haddr_in <= a;
        hwrite_in <= wr;
        wait_for(0, 3'h0);
        hsel_in <= 1'b0;
        htrans_in <= 2'h0;
        hwdata_in <= d;
        wait_for(0, 3'h0);
        rd = hrdata_out;
        chk4(4'(hresp_out), 4'h0, "okay");
    endtask

    task automatic check_push(input int first, input logic [2:0] prev);
        wait_for(1, 3'h0);
        for (int s = first; s < 7; s++) begin
            chk4(4'(push_slot_out), 4'(s), "slot");
            if (s == 6) begin
                chk4(4'(push_data_out[24:22]), 4'(prev), "saved");
            end else begin
                chk32(push_data_out,
                      s == 5 ? 32'h100 : 32'h1234_5678, "data");
            end
            @(posedge clock_in);
        end
        chk4(4'(push_valid_out), 4'h0, "push end");
    endtask

    initial begin
        tick(20);
        rst_b_in <= 1'b1;
        tick(3);
        foreach (rows[i]) begin
            ahb(1'b1, 32'h0, rows[i].sw);
            req <= rows[i].req;
            tick(2);
            chk4(deny, rows[i].deny, "deny");
            req <= 6'h0;
        end
        ahb(1'b1, 32'h0, 32'h0040_003f);
        ahb(1'b0, 32'h0, 32'h0);
        chk32(rd, 32'h0000_003f, "app word");
        dbg_in <= 1'b1;
        tick(1);
        dbg_in <= 1'b0;
        tick(2);
        chk4(4'(debug_state_out), 4'h1, "debug on");
        chk4(status_word_out[20:17], 4'hf, "masks");
        req <= 6'h30;
        tick(2);
        chk4(deny, 4'h0, "debug deny");
        req <= 6'h0;
        ahb(1'b0, 32'h0, 32'h0);
        ahb(1'b1, 32'h0, rd & 32'hfffd_ffff);
        ahb(1'b0, 32'h0, 32'h0);
        chk4(rd[20:17], 4'he, "one level");
        restore <= 32'h0040_0000;
        ev_ret <= 1'b1;
        tick(1);
        ev_ret <= 1'b0;
        tick(2);
        chk4(4'(debug_state_out), 4'h1, "still debug");
        dbg_ret <= 1'b1;
        tick(1);
        dbg_ret <= 1'b0;
        tick(2);
        chk4(4'(debug_state_out), 4'h0, "debug off");
        chk32(status_word_out, 32'h0002_003f, "restored");
        rst_b_in <= 1'b0;
        tick(2);
        chk32(status_word_out, STATUS_WORD_RESET, "reset");
        rst_b_in <= 1'b1;
        tick(3);
        ahb(1'b0, 32'(MODE_STATE_ADDR), 32'h0);
        chk32(rd, 32'h0000_0079, "mode state");
        ahb(1'b0, 32'h0000_0008, 32'h0);
        chk32(rd, 32'h0, "unmapped");
        ahb(1'b1, 32'h0, 32'h0040_0000);
        irq <= 4'h1;
        check_push(0, MODE_SUPERVISOR);
        wait_for(2, MODE_LEVEL_ZERO);
        irq <= 4'h0;
        nmi <= 1'b1;
        check_push(5, MODE_LEVEL_ZERO);
        wait_for(2, MODE_NMI);
        nmi <= 1'b0;
        exc <= 1'b1;
        irq <= 4'h3;
        repeat (12) begin
            @(posedge clock_in);
            chk4(4'(push_valid_out), 4'h0, "no preempt");
        end
        ev_ret <= 1'b1;
        tick(1);
        ev_ret <= 1'b0;
        check_push(5, MODE_SUPERVISOR);
        wait_for(2, MODE_EXCEPTION);
        exc <= 1'b0;
        irq <= 4'h0;
        report_and_stop();
    end
endmodule // tb_top
